// ---- dcpf_pkg.sv ----
// Package: constants and types for the data-cache prefetch block
package dcpf_pkg;
   localparam int          ADDR_W          = 32;
   localparam int          OPC_W           = 8;
   localparam int          DISP_W          = 7;
   localparam int          SLOT_W          = 3;
   localparam int          BLOCK_BYTES     = 64;
   localparam int          MAX_OUTSTANDING = 2;
   localparam int          CNT_W           = 2;
   localparam logic [7:0]  OPC_HALF_IDX    = 8'hD3;
   localparam logic [7:0]  OPC_WORD_IDX    = 8'hD4;
   localparam logic [7:0]  OPC_DISP        = 8'hD1;
   localparam logic [2:0]  SLOT_PREFETCH   = 3'h5;
   localparam logic [1:0]  CNT_RESET       = 2'h0;
   localparam logic [31:0] ADDR_RESET      = 32'h0000_0000;
   localparam int          DISP_SHIFT      = 2;
   localparam int          HALF_SHIFT      = 1;
   localparam int          WORD_SHIFT      = 2;

   typedef struct packed {
      logic              valid;
      logic [SLOT_W-1:0] slot;
      logic [OPC_W-1:0]  opcode;
      logic              guard_used;
      logic [31:0]       guard_val;
      logic [31:0]       base_source_register;
      logic [31:0]       index_source_register;
      logic [DISP_W-1:0] disp_mod;
   } dcpf_issue_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } dcpf_fill_req_t;
endpackage : dcpf_pkg

// ---- dcpf_prefetch.sv ----
// Prefetch unit: decodes, computes block address, filters and issues fills
// Notes on behaviour
// - Block mask is inverse of block size minus one, applied to every address.
// - Halfword-indexed prefetch uses base plus twice index, aligned, fills the block.
// - Word-indexed prefetch uses base plus four times index, aligned, fills the block.
// - Displacement prefetch adds displacement to base, aligns, fills the block.
// - Opcodes 211 halfword-indexed, 212 word-indexed, 209 displacement.
// - Indexed forms use two registers, displacement one; no destination written.
// - Accepted only in issue slot 5 of the speculative memory unit.
// - Drop prefetch when the target block already hits in the cache.
// - At most two misses outstanding; drop prefetch when two are pending. An accept and a demand miss in one cycle add only one to the count.
// - With a guard, prefetch only when its lowest bit is one.
// - Dropped prefetch has no effect, exception or stall.
module dcpf_prefetch #(
   parameter int BLOCK_BYTES = dcpf_pkg::BLOCK_BYTES,
   parameter int MAX_OUT     = dcpf_pkg::MAX_OUTSTANDING
) (
   input  wire logic                    I_CLK,
   input  wire logic                    I_RST_N,
   input  wire dcpf_pkg::dcpf_issue_t   I_ISSUE,
   input  wire logic                    I_CACHE_HIT,
   input  wire logic                    I_MISS_START,
   input  wire logic                    I_FILL_DONE,
   output logic [31:0]                  O_LOOKUP_ADDR,
   output dcpf_pkg::dcpf_fill_req_t     O_FILL_REQ,
   output logic                         O_DROPPED,
   output logic [1:0]                   O_OUTSTANDING,
   output logic                         O_STALL
);
   localparam logic [31:0] BLK_MASK = ~(32'(BLOCK_BYTES) - 32'h0000_0001);

   logic        is_half;
   logic        is_word;
   logic        is_disp;
   logic        is_pref;
   logic        guard_ok;
   logic [31:0] disp_ext;
   logic [31:0] raw_addr;
   logic [31:0] blk_addr;
   logic        full;
   logic        take;
   logic [1:0]  cnt_q;
   logic [1:0]  cnt_d;
   logic        req_q;
   logic        req_d;
   logic [31:0] addr_q;
   logic [31:0] addr_d;
   logic        drop_q;
   logic        drop_d;
   logic        pref_live;
   logic        inc;
   logic        dec;

   // Decode
   always_comb begin
      is_half = I_ISSUE.opcode == dcpf_pkg::OPC_HALF_IDX;
      is_word = I_ISSUE.opcode == dcpf_pkg::OPC_WORD_IDX;
      is_disp = I_ISSUE.opcode == dcpf_pkg::OPC_DISP;
      is_pref = I_ISSUE.valid && (I_ISSUE.slot == dcpf_pkg::SLOT_PREFETCH)
                && (is_half || is_word || is_disp);
      guard_ok = !I_ISSUE.guard_used || I_ISSUE.guard_val[0];
   end

   // Address computation
   always_comb begin
      disp_ext = {{(32 - dcpf_pkg::DISP_W - dcpf_pkg::DISP_SHIFT){I_ISSUE.disp_mod[6]}},
                  I_ISSUE.disp_mod, 2'h0};
      if (is_half) begin
         raw_addr = I_ISSUE.base_source_register
                    + (I_ISSUE.index_source_register << dcpf_pkg::HALF_SHIFT);
      end else if (is_word) begin
         raw_addr = I_ISSUE.base_source_register
                    + (I_ISSUE.index_source_register << dcpf_pkg::WORD_SHIFT);
      end else begin
         raw_addr = I_ISSUE.base_source_register + disp_ext;
      end
      blk_addr = raw_addr & BLK_MASK;
   end

   // Acceptance filter
   always_comb begin
      pref_live = is_pref && guard_ok;
      full      = cnt_q >= 2'(MAX_OUT);
      take      = pref_live && !I_CACHE_HIT && !full;
   end

   take_hit_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      I_CACHE_HIT |-> !take)
      else $error("hit block accepted for fill");

   take_full_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      full |-> !take)
      else $error("fill accepted with count at limit");

   take_live_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (pref_live && !I_CACHE_HIT && !full) |-> take)
      else $error("eligible prefetch not accepted");

   // Fill request: one pulse per accepted prefetch, address held between
   always_comb begin
      req_d  = take;
      addr_d = take ? blk_addr : addr_q;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         req_q  <= 1'h0;
         addr_q <= dcpf_pkg::ADDR_RESET;
      end else begin
         req_q  <= req_d;
         addr_q <= addr_d;
      end
   end

   req_pulse_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      take |=> O_FILL_REQ.valid)
      else $error("accepted prefetch gave no fill request");

   req_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      !take |=> !O_FILL_REQ.valid)
      else $error("fill request without acceptance");

   addr_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      !take |=> $stable(O_FILL_REQ.addr))
      else $error("fill address moved without acceptance");

   // Drop flag: eligible prefetch refused by hit or full count
   always_comb begin
      drop_d = pref_live && !take;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         drop_q <= 1'h0;
      end else begin
         drop_q <= drop_d;
      end
   end

   hit_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (pref_live && I_CACHE_HIT) |=> O_DROPPED)
      else $error("hit prefetch not flagged as dropped");

   full_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (pref_live && full) |=> O_DROPPED)
      else $error("prefetch at full count not flagged as dropped");

   drop_excl_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      !(O_DROPPED && O_FILL_REQ.valid))
      else $error("drop and fill request together");

   // Outstanding counter: accept and demand miss share one increment
   always_comb begin
      inc   = take || I_MISS_START;
      dec   = I_FILL_DONE && (cnt_q != 2'h0);
      cnt_d = cnt_q;
      if (inc && !I_FILL_DONE && (cnt_q < 2'(MAX_OUT))) begin
         cnt_d = cnt_q + 2'h1;
      end else if (!inc && dec) begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         cnt_q <= dcpf_pkg::CNT_RESET;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   cnt_up_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (inc && !I_FILL_DONE && (cnt_q < 2'(MAX_OUT))) |=> O_OUTSTANDING == $past(cnt_q) + 2'h1)
      else $error("outstanding count did not rise");

   cnt_down_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (!inc && dec) |=> O_OUTSTANDING == $past(cnt_q) - 2'h1)
      else $error("outstanding count did not fall");

   cnt_cancel_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (take && I_FILL_DONE) |=> O_OUTSTANDING == $past(cnt_q))
      else $error("accept and fill done did not cancel");

   // Outputs
   assign O_LOOKUP_ADDR = blk_addr;
   assign O_FILL_REQ    = '{valid: req_q, addr: addr_q};
   assign O_DROPPED     = drop_q;
   assign O_OUTSTANDING = cnt_q;
   assign O_STALL       = 1'h0;

   // Checks
   req_aligned_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_FILL_REQ.valid |-> (O_FILL_REQ.addr & ~BLK_MASK) == 32'h0000_0000)
      else $error("fill address not block aligned");
   hit_drop_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      I_CACHE_HIT |=> !O_FILL_REQ.valid)
      else $error("fill issued on cache hit");
   full_drop_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (cnt_q == 2'h2) |=> !O_FILL_REQ.valid)
      else $error("fill issued with two misses pending");
   guard_off_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_ISSUE.guard_used && !I_ISSUE.guard_val[0]) |=> !O_FILL_REQ.valid && !O_DROPPED)
      else $error("prefetch acted with false guard");
   slot_only_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_ISSUE.slot != dcpf_pkg::SLOT_PREFETCH) |=> !O_FILL_REQ.valid)
      else $error("prefetch taken outside slot five");
   cnt_bound_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      cnt_q <= 2'(MAX_OUT))
      else $error("outstanding count over limit");
   half_addr_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (take && is_half) |=> O_FILL_REQ.addr == (($past(I_ISSUE.base_source_register)
         + ($past(I_ISSUE.index_source_register) << 1)) & BLK_MASK))
      else $error("halfword-indexed address wrong");
   word_addr_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (take && is_word) |=> O_FILL_REQ.addr == (($past(I_ISSUE.base_source_register)
         + ($past(I_ISSUE.index_source_register) << 2)) & BLK_MASK))
      else $error("word-indexed address wrong");
   disp_addr_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (take && is_disp) |=> O_FILL_REQ.addr == (($past(I_ISSUE.base_source_register)
         + $past(disp_ext)) & BLK_MASK))
      else $error("displacement address wrong");
   no_stall_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_DROPPED |-> !O_STALL)
      else $error("drop caused a stall");

   // Lookup, decode, displacement, drop, fill request, guard, counter and reset checks
   lookup_align_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (O_LOOKUP_ADDR & ~BLK_MASK) == 32'h0000_0000)
      else $error("lookup address not block aligned");

   opc_other_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_ISSUE.valid && !(is_half || is_word || is_disp)) |=> !O_FILL_REQ.valid && !O_DROPPED)
      else $error("unknown opcode acted on");

   invalid_op_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      !I_ISSUE.valid |=> !O_FILL_REQ.valid && !O_DROPPED)
      else $error("empty issue slot acted on");

   slot_drop_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_ISSUE.slot != dcpf_pkg::SLOT_PREFETCH) |=> !O_DROPPED)
      else $error("drop flagged outside slot five");

   rst_clear_a: assert property (@(posedge I_CLK)
      !I_RST_N |=> O_OUTSTANDING == 2'h0 && !O_FILL_REQ.valid && !O_DROPPED)
      else $error("reset did not clear state");

   disp_step_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      disp_ext[1:0] == 2'h0)
      else $error("displacement not a multiple of four");

   disp_sign_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      disp_ext[31:8] == {24{I_ISSUE.disp_mod[6]}})
      else $error("displacement not sign extended");

   disp_max_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_ISSUE.disp_mod == 7'h3F) |-> disp_ext == 32'h0000_00FC)
      else $error("largest displacement wrong");

   disp_min_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_ISSUE.disp_mod == 7'h40) |-> disp_ext == 32'hFFFF_FF00)
      else $error("smallest displacement wrong");

   drop_cause_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_DROPPED |-> $past(pref_live))
      else $error("drop flagged without a live prefetch");

   req_cause_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_FILL_REQ.valid |-> !$past(I_CACHE_HIT))
      else $error("fill request follows a hit");

   req_addr_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_FILL_REQ.valid |-> O_FILL_REQ.addr == $past(O_LOOKUP_ADDR))
      else $error("fill address differs from lookup address");

   guard_on_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (is_pref && I_ISSUE.guard_used && I_ISSUE.guard_val[0]) |=> O_FILL_REQ.valid || O_DROPPED)
      else $error("true guard prefetch ignored");

   no_guard_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (is_pref && !I_ISSUE.guard_used) |=> O_FILL_REQ.valid || O_DROPPED)
      else $error("unguarded prefetch ignored");

   cnt_sat_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (cnt_q == 2'(MAX_OUT) && I_MISS_START && !I_FILL_DONE) |=> O_OUTSTANDING == 2'(MAX_OUT))
      else $error("outstanding count left its limit");

   cnt_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (!inc && !I_FILL_DONE) |=> $stable(O_OUTSTANDING))
      else $error("outstanding count moved while idle");

   lookup_half_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_half |-> O_LOOKUP_ADDR == ((I_ISSUE.base_source_register
         + (I_ISSUE.index_source_register << 1)) & BLK_MASK))
      else $error("halfword-indexed lookup wrong");

   lookup_word_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_word |-> O_LOOKUP_ADDR == ((I_ISSUE.base_source_register
         + (I_ISSUE.index_source_register << 2)) & BLK_MASK))
      else $error("word-indexed lookup wrong");

   lookup_disp_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_disp |-> O_LOOKUP_ADDR == ((I_ISSUE.base_source_register + disp_ext) & BLK_MASK))
      else $error("displacement lookup wrong");

   miss_up_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (I_MISS_START && !take && !I_FILL_DONE && (cnt_q < 2'(MAX_OUT)))
         |=> O_OUTSTANDING == $past(cnt_q) + 2'h1)
      else $error("demand miss not counted");
endmodule : dcpf_prefetch

// ---- dcpf_mem_model.sv ----
// Far side model: tag lookup and main-memory fill completion
module dcpf_mem_model (
   input  wire logic                     i_clk,
   input  wire logic                     i_rst_n,
   input  wire dcpf_pkg::dcpf_fill_req_t i_fill_req,
   input  wire logic [31:0]              i_lookup_addr,
   input  wire logic [31:0]              i_cached_addr,
   input  wire logic                     i_release,
   output logic                          o_cache_hit,
   output logic                          o_fill_done
);
   int   pending_q;
   logic ok;
   assign o_cache_hit = (i_lookup_addr == i_cached_addr);
   assign ok = i_release && (pending_q > 0 || i_fill_req.valid);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pending_q <= 0;
         o_fill_done <= 1'b0;
      end else begin
         o_fill_done <= ok;
         pending_q <= pending_q + int'(i_fill_req.valid) - int'(ok);
      end
   end
endmodule : dcpf_mem_model

// ---- dcpf_prefetch_tb_top.sv ----
// Testbench for the data-cache prefetch unit
module dcpf_prefetch_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                     clk = 1'b0, rst_n = 1'b0, miss = 1'b0, rel = 1'b0, hit, done;
   logic                     drop, stall;
   logic [31:0]              look, cached = 32'hFFFF_FFC0;
   logic [1:0]               outst;
   dcpf_pkg::dcpf_issue_t    issue = '0;
   dcpf_pkg::dcpf_fill_req_t fill;
   int                       err_count = 0, total_checks = 0, exp_cnt = 0;
   always #5 clk = ~clk;
   dcpf_prefetch u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_ISSUE(issue), .I_CACHE_HIT(hit),
      .I_MISS_START(miss), .I_FILL_DONE(done), .O_LOOKUP_ADDR(look), .O_FILL_REQ(fill),
      .O_DROPPED(drop), .O_OUTSTANDING(outst), .O_STALL(stall));
   dcpf_mem_model u_mem (.i_clk(clk), .i_rst_n(rst_n), .i_fill_req(fill),
      .i_lookup_addr(look), .i_cached_addr(cached), .i_release(rel), .o_cache_hit(hit),
      .o_fill_done(done));
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic rls();
      issue.valid = 1'b0;
      rel = 1'b1;
      step();
      rel = 1'b0;
      step();
      exp_cnt--;
      chk(outst === exp_cnt[1:0], "count after fill done");
   endtask : rls
   task automatic op(input logic [7:0] c, input logic [2:0] s, input logic [31:0] g, b, x,
         input logic [6:0] d, input logic [31:0] ea, input logic ef, ed, r);
      issue = '{1'b1, s, c, 1'b1, g, b, x, d};
      step();
      if (ef) exp_cnt++;
      chk(fill.valid === ef && drop === ed && stall === 1'b0, "op outcome");
      chk(!ef || fill.addr === ea, "fill address");
      chk(!ef || look === ea, "lookup address");
      chk(outst === exp_cnt[1:0], "outstanding count");
      if (r) rls();
   endtask : op
   task automatic t_addr();
      op(8'hD3, 3'h5, 1, 32'hABCD, 32'hC, 0, 32'hABC0, 1, 0, 1);
      op(8'hD4, 3'h5, 1, 32'hABCD, 32'hD, 0, 32'hAC00, 1, 0, 1);
      op(8'hD1, 3'h5, 1, 32'hABFF, 0, 7'h01, 32'hAC00, 1, 0, 1);
      op(8'hD1, 3'h5, 1, 32'hABCD, 0, 7'h40, 32'hAAC0, 1, 0, 1);
      op(8'hD1, 3'h5, 1, 32'hABCD, 0, 7'h3F, 32'hACC0, 1, 0, 1);
      op(8'hD3, 3'h5, 1, 32'hFFFF_FFF0, 32'h8, 0, 32'h0, 1, 0, 1);
      $display("test addr done");
   endtask : t_addr
   task automatic t_refuse();
      op(8'hD2, 3'h5, 1, 32'hABCD, 0, 0, 0, 0, 0, 0);
      op(8'hD3, 3'h4, 1, 32'hABCD, 0, 0, 0, 0, 0, 0);
      op(8'hD3, 3'h5, 2, 32'hABCD, 0, 0, 0, 0, 0, 0);
      op(8'hD4, 3'h5, 3, 32'hABFF, 1, 0, 32'hAC00, 1, 0, 1);
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_hit();
      cached = 32'hABC0;
      op(8'hD3, 3'h5, 1, 32'hABCD, 32'hC, 0, 0, 0, 1, 0);
      op(8'hD1, 3'h5, 1, 32'hABFF, 0, 7'h01, 32'hAC00, 1, 0, 1);
      cached = 32'hFFFF_FFC0;
      $display("test hit done");
   endtask : t_hit
   task automatic t_full();
      issue.valid = 1'b0;
      miss = 1'b1;
      step();
      miss = 1'b0;
      exp_cnt++;
      op(8'hD4, 3'h5, 1, 32'h100, 32'h10, 0, 32'h140, 1, 0, 0);
      op(8'hD1, 3'h5, 1, 32'h400, 0, 0, 0, 0, 1, 0);
      op(8'hD3, 3'h5, 1, 32'h500, 0, 0, 0, 0, 1, 1);
      op(8'hD1, 3'h5, 1, 32'h800, 0, 0, 32'h800, 1, 0, 1);
      $display("test full done");
   endtask : t_full
   task automatic t_reset();
      issue.valid = 1'b0;
      rst_n = 1'b0;
      step();
      step();
      rst_n = 1'b1;
      exp_cnt = 0;
      step();
      chk(outst === 2'h0 && fill.valid === 1'b0 && drop === 1'b0, "mid-run reset");
      $display("test reset done");
   endtask : t_reset
   task automatic t_merge();
      miss = 1'b1;
      op(8'hD1, 3'h5, 1, 32'hA00, 0, 0, 32'hA00, 1, 0, 0);
      miss = 1'b0;
      issue.valid = 1'b0;
      rel = 1'b1;
      step();
      rel = 1'b0;
      exp_cnt--;
      op(8'hD1, 3'h5, 1, 32'hC00, 0, 0, 32'hC00, 1, 0, 1);
      $display("test merge done");
   endtask : t_merge
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   initial begin
      #200000;
      err_count++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      step();
      chk(outst === 2'h0 && fill.valid === 1'b0 && drop === 1'b0, "reset state");
      t_addr();
      t_refuse();
      t_hit();
      t_full();
      t_reset();
      t_merge();
      give_verdict();
   end
endmodule : dcpf_prefetch_tb_top
